// >>> core/edob_top.sv
`timescale 1ns/1ps
`default_nettype none

module edob_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [edob_pkg::EDOB_ADDR_W-1:0] paddr,
    input wire logic [edob_pkg::EDOB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [edob_pkg::EDOB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [edob_pkg::EDOB_BANK_W-1:0] chan_out_49_64,
    output logic [edob_pkg::EDOB_BANK_W-1:0] chan_out_65_80,
    output logic [edob_pkg::EDOB_BANK_W-1:0] chan_out_81_96
);
    import edob_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Each bank fills the two low byte lanes of a data word
    if (EDOB_BANK_W != 16) begin : g_chk_bank_w
        $error("Bank width must be 16 bits");
    end

    // Read data is one full bus word with the bank in its low half
    if (EDOB_DATA_W != 32) begin : g_chk_data_w
        $error("Data width must be 32 bits");
    end

    // The decoder and the channel ports serve exactly three banks
    if (EDOB_NUM_BANKS != 3) begin : g_chk_banks
        $error("Exactly three banks are served");
    end

    // Byte addresses must fit the address bus without loss
    if (EDOB_ADDR_W < 16) begin : g_chk_addr_w
        $error("Address bus narrower than 16 bits");
    end

    // A byte address wider than a data word is not served
    if (EDOB_ADDR_W > 32) begin : g_chk_addr_max
        $error("Address bus wider than 32 bits");
    end

    // The byte address is four times the index, with no carry lost
    if ((EDOB_IDX_TWO_UPPER >= 16'h4000) ||
        (EDOB_IDX_THREE_LOWER >= 16'h4000) ||
        (EDOB_IDX_THREE_UPPER >= 16'h4000)) begin : g_chk_idx
        $error("Register index too large for the address bus");
    end

    // Every bank takes one aligned word
    if ((EDOB_ADDR_TWO_UPPER[1:0] != 2'h0) ||
        (EDOB_ADDR_THREE_LOWER[1:0] != 2'h0) ||
        (EDOB_ADDR_THREE_UPPER[1:0] != 2'h0)) begin : g_chk_align
        $error("Bank addresses must be word aligned");
    end

    // Two banks on one address would make the decode ambiguous
    if ((EDOB_ADDR_TWO_UPPER == EDOB_ADDR_THREE_LOWER) ||
        (EDOB_ADDR_TWO_UPPER == EDOB_ADDR_THREE_UPPER) ||
        (EDOB_ADDR_THREE_LOWER == EDOB_ADDR_THREE_UPPER)) begin : g_chk_uniq
        $error("Bank addresses must differ");
    end

    // Every channel must start inactive after reset
    if (EDOB_BANK_RESET != '0) begin : g_chk_reset
        $error("Bank reset value must be all zero");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Maps a byte address to a bank number; 3 marks an unmapped address
    function automatic logic [1:0] edob_decode(
        input logic [EDOB_ADDR_W-1:0] addr
    );
        case (addr)
            EDOB_ADDR_TWO_UPPER: edob_decode = 2'h0;
            EDOB_ADDR_THREE_LOWER: edob_decode = 2'h1;
            EDOB_ADDR_THREE_UPPER: edob_decode = 2'h2;
            default: edob_decode = 2'h3;
        endcase
    endfunction

    // Replaces the byte lanes of a bank value that the strobe selects
    function automatic logic [EDOB_BANK_W-1:0] edob_lane_merge(
        input logic [EDOB_BANK_W-1:0] old_val,
        input logic [EDOB_DATA_W-1:0] data,
        input logic [3:0] strb
    );
        edob_lane_merge = old_val;
        if (strb[0]) begin
            edob_lane_merge[7:0] = data[7:0];
        end
        if (strb[1]) begin
            edob_lane_merge[15:8] = data[15:8];
        end
    endfunction

    // Forms a read word from one bank value, upper half zero
    function automatic logic [EDOB_DATA_W-1:0] edob_read_word(
        input logic [EDOB_BANK_W-1:0] val
    );
        edob_read_word = {16'h0000, val};
    endfunction

    logic [1:0] sel_bank;
    logic mapped;
    logic acc_phase;
    logic wr_acc;
    logic rd_acc;
    logic [EDOB_NUM_BANKS-1:0] wr_en;
    logic [EDOB_BANK_W-1:0] bank_r [EDOB_NUM_BANKS];
    logic [EDOB_BANK_W-1:0] cur_val;
    logic [EDOB_BANK_W-1:0] wr_val;
    logic [EDOB_BANK_W-1:0] rd_val;

    // Bank selected by the address on the bus
    assign sel_bank = edob_decode(paddr);
    assign mapped = (sel_bank != 2'h3);

    // First access cycle only; pready is high in the second and ends it
    assign acc_phase = psel && penable && !pready;
    assign wr_acc = acc_phase && pwrite;
    assign rd_acc = acc_phase && !pwrite && mapped;

    // Present value of the addressed bank, base for a lane merge
    always_comb begin
        cur_val = bank_r[0];
        case (sel_bank)
            2'h0: cur_val = bank_r[0];
            2'h1: cur_val = bank_r[1];
            2'h2: cur_val = bank_r[2];
            default: cur_val = bank_r[0];
        endcase
    end

    // Lanes not strobed keep their channels as they are
    assign wr_val = edob_lane_merge(cur_val, pwdata, pstrb);

    ////////////////////////////////////////////////////////////////////////
    // Output banks

    // One write strobe per bank; an unmapped address raises none
    for (genvar w = 0; w < EDOB_NUM_BANKS; w++) begin : g_wr_en
        assign wr_en[w] = wr_acc && (sel_bank == 2'(w));
    end

    // One bank per generate step; each bit is one channel, bit 0 lowest
    for (genvar b = 0; b < EDOB_NUM_BANKS; b++) begin : g_bank
        always_ff @(posedge core_clk) begin
            if (rst) begin
                bank_r[b] <= EDOB_BANK_RESET;
            end else if (wr_en[b]) begin
                bank_r[b] <= wr_val;
            end
        end
    end

    // Channel pins follow the bank registers with no logic between
    assign chan_out_49_64 = bank_r[0];
    assign chan_out_65_80 = bank_r[1];
    assign chan_out_81_96 = bank_r[2];

    ////////////////////////////////////////////////////////////////////////
    // Apb response

    // One-cycle pready pulse in the second access cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= acc_phase;
        end
    end

    // Error flag rides with pready for an unmapped address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= acc_phase && !mapped;
        end
    end

    // Present state of the addressed channel bank for a read
    always_comb begin
        rd_val = chan_out_81_96;
        case (sel_bank)
            2'h0: rd_val = chan_out_49_64;
            2'h1: rd_val = chan_out_65_80;
            default: rd_val = chan_out_81_96;
        endcase
    end

    // Read data stands only while pready does, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (rd_acc) begin
            prdata <= edob_read_word(rd_val);
        end else begin
            prdata <= '0;
        end
    end

endmodule

`default_nettype wire

// >>> core/edob_pkg.sv
package edob_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] EDOB_IDX_TWO_UPPER = 16'h1167;
    localparam logic [15:0] EDOB_IDX_THREE_LOWER = 16'h1168;
    localparam logic [15:0] EDOB_IDX_THREE_UPPER = 16'h1169;

    // Apb address width and word layout
    localparam int EDOB_ADDR_W = 16;
    localparam int EDOB_DATA_W = 32;
    localparam int EDOB_BANK_W = 16;
    localparam int EDOB_NUM_BANKS = 3;

    // Byte addresses
    localparam logic [EDOB_ADDR_W-1:0] EDOB_ADDR_TWO_UPPER =
        EDOB_ADDR_W'({EDOB_IDX_TWO_UPPER, 2'b00});
    localparam logic [EDOB_ADDR_W-1:0] EDOB_ADDR_THREE_LOWER =
        EDOB_ADDR_W'({EDOB_IDX_THREE_LOWER, 2'b00});
    localparam logic [EDOB_ADDR_W-1:0] EDOB_ADDR_THREE_UPPER =
        EDOB_ADDR_W'({EDOB_IDX_THREE_UPPER, 2'b00});

    // Reset value of every bank: all channels inactive
    localparam logic [EDOB_BANK_W-1:0] EDOB_BANK_RESET = 16'h0000;

endpackage

// >>> verification/edob_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
// Output pins: capture what the three banks drive each clock
module edob_chan_model (
    input wire logic core_clk,
    input wire logic [47:0] chan,
    output logic [47:0] seen
);
    always_ff @(posedge core_clk) seen <= chan;
endmodule
`default_nettype wire

// >>> verification/edob_chk.sv
`timescale 1ns/1ps
`default_nettype none
module edob_chk import edob_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] paddr,
    input wire logic [15:0] chan_out_49_64,
    input wire logic [15:0] chan_out_65_80,
    input wire logic [15:0] chan_out_81_96,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [3:0] pstrb
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // First access edge of a full-lane write
    wire wr = psel && penable && pwrite && !pready && pstrb[1:0] == 2'h3;
    a_two_upper: assert property (
        wr && paddr == EDOB_ADDR_TWO_UPPER |=>
        chan_out_49_64 == $past(pwdata[15:0])) else $error("bank 49 lost");
    a_three_lower: assert property (
        wr && paddr == EDOB_ADDR_THREE_LOWER |=>
        chan_out_65_80 == $past(pwdata[15:0])) else $error("bank 65 lost");
    a_three_upper: assert property (
        wr && paddr == EDOB_ADDR_THREE_UPPER |=>
        chan_out_81_96 == $past(pwdata[15:0])) else $error("bank 81 lost");
    a_read_state: assert property (
        pready && !pwrite && !pslverr && paddr == EDOB_ADDR_THREE_LOWER |->
        prdata == {16'h0000, chan_out_65_80})
        else $error("read differs from pins");
    a_hold_value: assert property (!wr |=> $stable(chan_out_49_64))
        else $error("bank 49 changed unwritten");
    a_reset_clear: assert property ($past(rst) |-> chan_out_81_96 == 0)
        else $error("bank 81 not cleared");
    cover property (wr);
    cover property (pready && pslverr);
    cover property (pready && !pwrite);
endmodule
bind edob_top edob_chk i_chk (.*);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import edob_pkg::*;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [15:0] paddr = 0, c1, c2, c3;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr;
    logic [47:0] seen;
    logic [15:0] ad [3] = '{EDOB_ADDR_TWO_UPPER, EDOB_ADDR_THREE_LOWER,
        EDOB_ADDR_THREE_UPPER};
    int error_cnt = 0, comparisons = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    edob_top i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
        .chan_out_49_64(c1), .chan_out_65_80(c2), .chan_out_81_96(c3));
    edob_chan_model i_chan (.core_clk, .chan({c3, c2, c1}), .seen);
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) if (++cyc > 3000) begin
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 0;
        for (int i = 0; i < 3; i++) begin
            apb(0, ad[i], 0);
            chk("reset", 0, rd);
        end
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            apb(1, ad[i], 32'hA5C3 << i);
            apb(0, ad[i], 0);
            chk("readback", (32'hA5C3 << i) & 32'hFFFF, rd);
            chk("pins", (32'hA5C3 << i) & 32'hFFFF,
                seen[16*i+:16]);
        end
        apb(1, ad[0], 0);
        apb(0, ad[0], 0);
        chk("clear", 0, rd);
        $display("test banks done");
        apb(1, 16'h4598, 32'hFFFF);
        apb(0, 16'h4598, 0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        chk("unmapped pins", 0, seen[15:0]);
        chk("unmapped upper pins", 32'h970C_4B86, seen[47:16]);
        $display("test unmapped done");
        end_of_test;
    end
endmodule
`default_nettype wire
